// ==== wdt_params.svh ====
// constants of the watchdog control block
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ==========================================
// register placement
`define WDT_CTRL_ADDR      8'hc0
`define WDT_CTRL_BITBASE   5'h18
`define WDT_CTRL_RST       8'h10
`define WDT_PRE_RST        4'h1
`define WDT_RESP_RST       1'b0

// ==========================================
// field positions inside the control register
`define WDT_PRE_MSB        7
`define WDT_PRE_LSB        4
`define WDT_BIT_RESP       3
`define WDT_BIT_FLAG       2
`define WDT_BIT_ARM        1
`define WDT_BIT_UNLOCK     0
`define WDT_BIT_UNLOCK_IDX 3'h0

// ==========================================
// timing in crystal periods
`define WDT_BASE_TICKS     17'h00200
`define WDT_PRE_IMMEDIATE  4'h8
`define WDT_CNT_W          17

`endif

// ==== wdt_pkg.sv ====
// types shared by the watchdog control block
package wdt_pkg;

  // ==========================================
  // write-unlock sequence states
  typedef enum logic [1:0] {
    UL_LOCKED,
    UL_OPEN,
    UL_NEXT
  } wdt_unlock_type;

endpackage : wdt_pkg

// ==== wdt_pin_sync.sv ====
// crystal pin synchroniser with edge pulse
`include "wdt_params.svh"

module wdt_pin_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // raw pin
  input  wire logic pin_in,
  // one-cycle pulse on each filtered rising edge
  output logic      rise_pulse
);

  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  logic rise_ff;
  logic nxt_level;

  // ==========================================
  // three-stage synchroniser
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // level changes only when stages two and three agree
  always_comb begin
    nxt_level = (sync2_ff == sync3_ff) ? sync3_ff : level_ff;
  end

  // filtered level and rising edge, crystal time base
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      rise_ff  <= nxt_level & ~level_ff;
    end
  end

  assign rise_pulse = rise_ff;

  // ==========================================
  // checks
  a_pulse_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rise_ff |=> !rise_ff) else $error("crystal tick pulse lasted two cycles");

endmodule : wdt_pin_sync

// ==== wdt_tick_counter.sv ====
// crystal tick counter with programmable limit
`include "wdt_params.svh"

module wdt_tick_counter (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  // control
  input  wire logic                  tick,
  input  wire logic                  clear,
  input  wire logic                  run,
  input  wire logic [`WDT_CNT_W-1:0] limit,
  // one-cycle pulse when the limit is reached
  output logic                       expire
);

  logic [`WDT_CNT_W-1:0] count_ff;
  logic                  expire_ff;
  logic [`WDT_CNT_W-1:0] nxt_count;

  // next count, wraps to zero at the limit
  always_comb begin
    nxt_count = count_ff + 1'b1;
  end

  // ==========================================
  // counting, restarted by clear or when idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_ff  <= '0;
      expire_ff <= 1'b0;
    end else if (clear || !run) begin
      count_ff  <= '0;
      expire_ff <= 1'b0;
    end else if (tick) begin
      if (nxt_count >= limit) begin
        count_ff  <= '0;
        expire_ff <= 1'b1;
      end else begin
        count_ff  <= nxt_count;
        expire_ff <= 1'b0;
      end
    end else begin
      expire_ff <= 1'b0;
    end
  end

  assign expire = expire_ff;

  // ==========================================
  // checks
  a_count_below: assert property (@(posedge clk_sys) disable iff (!reset_n)
    run && !clear && $stable(limit) |-> count_ff < limit)
    else $error("count passed its limit");
  a_count_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clear |=> count_ff == '0 && !expire_ff)
    else $error("rearm did not clear count");
  a_expire_cause: assert property (@(posedge clk_sys) disable iff (!reset_n)
    expire_ff |-> $past(tick) && $past(run))
    else $error("expiry without a tick");

endmodule : wdt_tick_counter

// ==== wdt_control.sv ====
// watchdog control register, unlock sequence and expiry response
`include "wdt_params.svh"

module wdt_control (
  // clock and external hardware reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // crystal pin
  input  wire logic       xtal_clk_in,
  // byte access
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // bit access
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wr,
  input  wire logic       bit_wdata,
  // core and supply events
  input  wire logic       instr_done,
  input  wire logic       supply_monitor_irq,
  // expiry outputs
  output logic            wdt_reset_req,
  output logic            wdt_irq
);

  // ==========================================
  // state
  logic [3:0]                  timeout_sel_ff;
  logic                        expiry_response_select_ff;
  logic                        timeout_flag_ff;
  logic                        arm_bit_ff;
  wdt_pkg::wdt_unlock_type     unlock_ff;
  logic [7:0]                  sfr_rdata_ff;
  logic                        wdt_reset_req_ff;
  logic                        wdt_irq_ff;

  logic [7:0]                  ctrl_view;
  logic                        byte_hit;
  logic                        bit_hit;
  logic                        unlock_set;
  logic                        wr_acc;
  logic [7:0]                  wr_val;
  logic                        kick;
  logic                        xtal_tick;
  logic                        cnt_expire;
  logic                        cnt_run;
  logic [`WDT_CNT_W-1:0]       cnt_limit;
  logic                        imm_expire;
  logic                        expire_evt;
  logic                        reset_expire;
  logic                        irq_expire;
  wdt_pkg::wdt_unlock_type     nxt_unlock;

  // ==========================================
  // register view, unlock bit reads as one while the sequence is open
  always_comb begin
    ctrl_view                            = 8'h00;
    ctrl_view[`WDT_PRE_MSB:`WDT_PRE_LSB] = timeout_sel_ff;
    ctrl_view[`WDT_BIT_RESP]             = expiry_response_select_ff;
    ctrl_view[`WDT_BIT_FLAG]             = timeout_flag_ff;
    ctrl_view[`WDT_BIT_ARM]              = arm_bit_ff;
    ctrl_view[`WDT_BIT_UNLOCK]           = (unlock_ff != wdt_pkg::UL_LOCKED);
  end

  // address decode for byte and bit access
  always_comb begin
    byte_hit   = sfr_wr && (sfr_addr == `WDT_CTRL_ADDR);
    bit_hit    = bit_wr && (bit_addr[7:3] == `WDT_CTRL_BITBASE);
    unlock_set = bit_hit && (bit_addr[2:0] == `WDT_BIT_UNLOCK_IDX) && bit_wdata;
  end

  // accepted write and its merged value, only right after unlock
  always_comb begin
    wr_val = ctrl_view;
    wr_acc = 1'b0;
    if (unlock_ff == wdt_pkg::UL_NEXT) begin
      if (byte_hit) begin
        wr_acc = 1'b1;
        wr_val = sfr_wdata;
      end else if (bit_hit && (bit_addr[2:0] != `WDT_BIT_UNLOCK_IDX)) begin
        wr_acc               = 1'b1;
        wr_val[bit_addr[2:0]] = bit_wdata;
      end
    end
  end

  // ==========================================
  // unlock sequence: set, its own instruction ends, next one may write
  always_comb begin
    nxt_unlock = unlock_ff;
    unique case (unlock_ff)
      wdt_pkg::UL_LOCKED: begin
        if (unlock_set) begin
          nxt_unlock = instr_done ? wdt_pkg::UL_NEXT : wdt_pkg::UL_OPEN;
        end
      end
      wdt_pkg::UL_OPEN: begin
        if (instr_done) begin
          nxt_unlock = wdt_pkg::UL_NEXT;
        end
      end
      wdt_pkg::UL_NEXT: begin
        if (wr_acc || instr_done) begin
          nxt_unlock = wdt_pkg::UL_LOCKED;
        end
      end
      default: begin
        nxt_unlock = wdt_pkg::UL_LOCKED;
      end
    endcase
  end

  // unlock state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unlock_ff <= wdt_pkg::UL_LOCKED;
    end else begin
      unlock_ff <= nxt_unlock;
    end
  end

  // ==========================================
  // crystal time base and counter
  wdt_pin_sync u_xtal_sync (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .pin_in     (xtal_clk_in),
    .rise_pulse (xtal_tick)
  );

  // counter runs for codes 0..7, limit is 512 shifted by the code
  always_comb begin
    kick      = wr_acc && wr_val[`WDT_BIT_ARM];
    cnt_run   = arm_bit_ff && !timeout_sel_ff[3];
    cnt_limit = `WDT_BASE_TICKS << timeout_sel_ff[2:0];
  end

  wdt_tick_counter u_counter (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick    (xtal_tick),
    .clear   (kick),
    .run     (cnt_run),
    .limit   (cnt_limit),
    .expire  (cnt_expire)
  );

  // ==========================================
  // expiry decode
  always_comb begin
    // code eight resets at once, higher codes stay quiet
    imm_expire   = arm_bit_ff && (timeout_sel_ff == `WDT_PRE_IMMEDIATE) && !kick;
    // response select steers expiry to reset or interrupt
    reset_expire = imm_expire || (cnt_expire && arm_bit_ff && !expiry_response_select_ff);
    irq_expire   = cnt_expire && arm_bit_ff && expiry_response_select_ff;
    expire_evt   = reset_expire || irq_expire;
  end

  // ==========================================
  // prescale and response select
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timeout_sel_ff            <= `WDT_PRE_RST;
      expiry_response_select_ff <= `WDT_RESP_RST;
    end else if (wr_acc) begin
      timeout_sel_ff            <= wr_val[`WDT_PRE_MSB:`WDT_PRE_LSB];
      expiry_response_select_ff <= wr_val[`WDT_BIT_RESP];
    end
  end

  // timeout flag, set wins over a zero write, cleared by a zero write or hardware reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timeout_flag_ff <= 1'b0;
    end else if (expire_evt) begin
      timeout_flag_ff <= 1'b1;
    end else if (wr_acc && !wr_val[`WDT_BIT_FLAG]) begin
      timeout_flag_ff <= 1'b0;
    end
  end

  // arm bit, kept in interval mode, dropped on reset expiry or supply alarm
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arm_bit_ff <= 1'b0;
    end else if (wr_acc) begin
      arm_bit_ff <= wr_val[`WDT_BIT_ARM];
    end else if (reset_expire || supply_monitor_irq) begin
      arm_bit_ff <= 1'b0;
    end
  end

  // expiry pulses, interrupt line is the fixed high-priority one
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wdt_reset_req_ff <= 1'b0;
      wdt_irq_ff       <= 1'b0;
    end else begin
      wdt_reset_req_ff <= reset_expire;
      wdt_irq_ff       <= irq_expire;
    end
  end

  // read data, zero for other addresses
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_ff <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_ff <= (sfr_addr == `WDT_CTRL_ADDR) ? ctrl_view : 8'h00;
    end
  end

  assign sfr_rdata     = sfr_rdata_ff;
  assign wdt_reset_req = wdt_reset_req_ff;
  assign wdt_irq       = wdt_irq_ff;

  // ==========================================
  // checks
  a_flag_on_expiry: assert property (@(posedge clk_sys) disable iff (!reset_n)
    expire_evt |=> timeout_flag_ff) else $error("timeout did not set flag");
  a_flag_sw_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_acc && !wr_val[`WDT_BIT_FLAG] && !expire_evt |=> !timeout_flag_ff)
    else $error("zero write did not clear flag");
  a_flag_survives: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wdt_reset_req_ff && timeout_flag_ff && !wr_acc |=> timeout_flag_ff)
    else $error("flag lost after watchdog reset");
  a_reset_response: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cnt_expire && arm_bit_ff && !expiry_response_select_ff && !wr_acc
    |=> wdt_reset_req_ff && !wdt_irq_ff && !arm_bit_ff)
    else $error("reset response wrong");
  a_irq_response: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cnt_expire && arm_bit_ff && expiry_response_select_ff
    |=> wdt_irq_ff && !wdt_reset_req_ff) else $error("interrupt response wrong");
  a_interval_keeps: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_expire && !wr_acc && !supply_monitor_irq |=> arm_bit_ff)
    else $error("interval timer stopped after interrupt");
  a_immediate_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    arm_bit_ff && timeout_sel_ff == `WDT_PRE_IMMEDIATE && !wr_acc
    |=> wdt_reset_req_ff && !arm_bit_ff) else $error("code eight did not reset");
  a_locked_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    unlock_ff != wdt_pkg::UL_NEXT |=> $stable(timeout_sel_ff)
    && $stable(expiry_response_select_ff)) else $error("write taken while locked");
  a_supply_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    supply_monitor_irq && !wr_acc |=> !arm_bit_ff)
    else $error("supply alarm left watchdog armed");
  a_read_view: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sfr_rd && sfr_addr == `WDT_CTRL_ADDR |=> sfr_rdata_ff == $past(ctrl_view))
    else $error("register read mismatch");

  // ==========================================
  // checks on writes, responses, reads and the unlock window
  a_arm_sw_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_acc && !wr_val[`WDT_BIT_ARM] |=> !arm_bit_ff)
    else $error("zero write left watchdog armed");
  a_field_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_acc |=> timeout_sel_ff == $past(wr_val[`WDT_PRE_MSB:`WDT_PRE_LSB])
    && expiry_response_select_ff == $past(wr_val[`WDT_BIT_RESP]))
    else $error("written fields not stored");
  a_reserved_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $stable(timeout_sel_ff) && timeout_sel_ff > `WDT_PRE_IMMEDIATE
    |=> !wdt_reset_req_ff && !wdt_irq_ff) else $error("reserved code caused expiry");
  a_unlock_closes: assert property (@(posedge clk_sys) disable iff (!reset_n)
    unlock_ff == wdt_pkg::UL_NEXT && instr_done |=> unlock_ff == wdt_pkg::UL_LOCKED)
    else $error("write window stayed open");
  a_one_response: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !(wdt_reset_req_ff && wdt_irq_ff)) else $error("reset and interrupt together");
  a_disarmed_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !arm_bit_ff |=> !wdt_reset_req_ff && !wdt_irq_ff)
    else $error("expiry while disarmed");
  a_read_other: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sfr_rd && sfr_addr != `WDT_CTRL_ADDR |=> sfr_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !sfr_rd |=> $stable(sfr_rdata_ff)) else $error("read data changed without a read");
  a_imm_no_irq: assert property (@(posedge clk_sys) disable iff (!reset_n)
    imm_expire |=> wdt_reset_req_ff && !wdt_irq_ff) else $error("code eight gave interrupt");
  a_kick_no_expiry: assert property (@(posedge clk_sys) disable iff (!reset_n)
    kick |=> !cnt_expire) else $error("rearm did not hold off expiry");

  c_irq_seen: cover property (@(posedge clk_sys) disable iff (!reset_n) wdt_irq_ff);
  c_reset_seen: cover property (@(posedge clk_sys) disable iff (!reset_n)
    wdt_reset_req_ff && !$past(imm_expire));
  c_immediate_seen: cover property (@(posedge clk_sys) disable iff (!reset_n) imm_expire);
  c_unlocked_write: cover property (@(posedge clk_sys) disable iff (!reset_n) wr_acc && kick);
  c_flag_cleared: cover property (@(posedge clk_sys) disable iff (!reset_n)
    timeout_flag_ff ##1 !timeout_flag_ff);

endmodule : wdt_control

// ==== tb_top.sv ====
// self-checking bench for the watchdog control register and expiry logic
`include "wdt_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================
  // signals
  logic       clk_sys;
  logic       reset_n;
  logic       xtal_clk_in;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [7:0] bit_addr;
  logic       bit_wr;
  logic       bit_wdata;
  logic       instr_done;
  logic       supply_monitor_irq;
  logic       wdt_reset_req;
  logic       wdt_irq;
  int         miscompares;
  int         num_checks;
  int         cycles;
  time        t_hit;
  logic [7:0] rd_v;
  int         i;

  // crystal period in ns, unrelated in phase to the core clock
  localparam int XTAL_NS = 420;
  localparam int LIMIT   = 60000;

  wdt_control u_dut (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .xtal_clk_in        (xtal_clk_in),
    .sfr_addr           (sfr_addr),
    .sfr_wr             (sfr_wr),
    .sfr_rd             (sfr_rd),
    .sfr_wdata          (sfr_wdata),
    .sfr_rdata          (sfr_rdata),
    .bit_addr           (bit_addr),
    .bit_wr             (bit_wr),
    .bit_wdata          (bit_wdata),
    .instr_done         (instr_done),
    .supply_monitor_irq (supply_monitor_irq),
    .wdt_reset_req      (wdt_reset_req),
    .wdt_irq            (wdt_irq)
  );

  // ==========================================
  // clocks and hang guard
  always #25 clk_sys = ~clk_sys;
  always #(XTAL_NS / 2) xtal_clk_in = ~xtal_clk_in;

  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================
  // tasks
  task summarize();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one instruction writing by byte or bit, optionally after the unlock instruction
  task access(input logic is_bit, input logic [7:0] addr, input logic [7:0] data,
              input logic unlock);
    if (unlock) begin
      @(negedge clk_sys);
      bit_wr     = 1'b1;
      bit_addr   = 8'hc0;
      bit_wdata  = 1'b1;
      instr_done = 1'b1;
    end
    @(negedge clk_sys);
    bit_wr     = is_bit;
    bit_addr   = addr;
    bit_wdata  = data[0];
    sfr_wr     = ~is_bit;
    sfr_addr   = addr;
    sfr_wdata  = data;
    instr_done = 1'b1;
    @(negedge clk_sys);
    bit_wr     = 1'b0;
    sfr_wr     = 1'b0;
    instr_done = 1'b0;
  endtask : access

  // byte read, data valid one cycle after the strobe
  task rd(input logic [7:0] addr, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_rd   = 1'b1;
    sfr_addr = addr;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    d      = sfr_rdata;
  endtask : rd

  // wait for one expiry pulse, check its kind and its distance from t0
  task expect_expiry(input logic want_irq, input int ticks, input time t0);
    logic got;
    logic got_irq;
    time  dt;
    int   n;
    got     = 1'b0;
    got_irq = 1'b0;
    for (n = 0; n < 20000 && !got; n++) begin
      @(negedge clk_sys);
      if (wdt_irq === 1'b1 || wdt_reset_req === 1'b1) begin
        got     = 1'b1;
        got_irq = wdt_irq;
      end
    end
    t_hit = $time;
    dt    = t_hit - t0;
    check({7'h00, got}, 8'h01);
    check({7'h00, got_irq}, {7'h00, want_irq});
    check({7'h00, dt + 1000 > ticks * XTAL_NS && dt < ticks * XTAL_NS + 1000}, 8'h01);
  endtask : expect_expiry

  // no expiry pulse of either kind for n cycles
  task quiet(input int n);
    int k;
    int hits;
    hits = 0;
    for (k = 0; k < n; k++) begin
      @(negedge clk_sys);
      if (wdt_irq !== 1'b0 || wdt_reset_req !== 1'b0) begin
        hits++;
      end
    end
    check({7'h00, hits != 0}, 8'h00);
  endtask : quiet

  // ==========================================
  // main sequence
  initial begin
    clk_sys            = 1'b0;
    xtal_clk_in        = 1'b0;
    reset_n            = 1'b0;
    sfr_addr           = 8'h00;
    sfr_wr             = 1'b0;
    sfr_rd             = 1'b0;
    sfr_wdata          = 8'h00;
    bit_addr           = 8'h00;
    bit_wr             = 1'b0;
    bit_wdata          = 1'b0;
    instr_done         = 1'b0;
    supply_monitor_irq = 1'b0;
    miscompares        = 0;
    num_checks         = 0;
    cycles             = 0;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    // reset value and unmapped read
    rd(8'hc0, rd_v);
    check(rd_v, `WDT_CTRL_RST);
    rd(8'hc1, rd_v);
    check(rd_v, 8'h00);
    // locked write and a write one instruction too late are dropped
    access(1'b0, 8'hc0, 8'h72, 1'b0);
    access(1'b0, 8'h80, 8'h55, 1'b1);
    access(1'b0, 8'hc0, 8'h72, 1'b0);
    rd(8'hc0, rd_v);
    check(rd_v, 8'h10);
    // interrupt response, shortest timeout, repeats as interval timer
    access(1'b0, 8'hc0, 8'h0a, 1'b1);
    expect_expiry(1'b1, 512, $time);
    rd(8'hc0, rd_v);
    check(rd_v, 8'h0e);
    expect_expiry(1'b1, 512, t_hit);
    // external hardware reset clears flag and arm
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    rd(8'hc0, rd_v);
    check(rd_v, 8'h10);
    // timely rearming holds expiry off
    for (i = 0; i < 3; i++) begin
      access(1'b0, 8'hc0, 8'h0a, 1'b1);
      quiet(3000);
    end
    access(1'b0, 8'hc0, 8'h10, 1'b1);
    rd(8'hc0, rd_v);
    check(rd_v, 8'h10);
    // reset response at prescale one; flag kept, arm dropped
    access(1'b0, 8'hc0, 8'h12, 1'b1);
    expect_expiry(1'b0, 1024, $time);
    rd(8'hc0, rd_v);
    check(rd_v, 8'h14);
    access(1'b1, 8'hc2, 8'h00, 1'b1);
    rd(8'hc0, rd_v);
    check(rd_v, 8'h10);
    // bit-set arm, then supply alarm clears it
    access(1'b1, 8'hc1, 8'h01, 1'b1);
    rd(8'hc0, rd_v);
    check(rd_v, 8'h12);
    @(negedge clk_sys);
    supply_monitor_irq = 1'b1;
    @(negedge clk_sys);
    supply_monitor_irq = 1'b0;
    rd(8'hc0, rd_v);
    check(rd_v, 8'h10);
    // immediate reset code, even with interrupt response chosen
    access(1'b0, 8'hc0, 8'h8a, 1'b1);
    expect_expiry(1'b0, 0, $time);
    rd(8'hc0, rd_v);
    check(rd_v & 8'hfb, 8'h88);
    // reserved code never expires
    access(1'b0, 8'hc0, 8'h9a, 1'b1);
    quiet(5000);
    rd(8'hc0, rd_v);
    check(rd_v & 8'hfb, 8'h9a);
    summarize();
  end

endmodule : tb_top
